// File: tcc_consts.svh
// register offsets, field positions and reset values of the timer block
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_OFF_CTRL_A   8'h00
`define TCC_OFF_CTRL_B   8'h04
`define TCC_OFF_COUNT    8'h08
`define TCC_OFF_CMP_A    8'h0c
`define TCC_OFF_CMP_B    8'h10
`define TCC_OFF_CMP_C    8'h14
`define TCC_OFF_CAPTURE  8'h18
`define TCC_OFF_FLAGS    8'h1c
`define TCC_OFF_IRQ_EN   8'h20
`define TCC_ADDR_W       8
`define TCC_WGM_LO_LSB   0
`define TCC_COM_LSB      2
`define TCC_WGM_HI_LSB   0
`define TCC_EDGE_BIT     2
`define TCC_SRC_BIT      3
`define TCC_PRE_LSB      4
`define TCC_FLG_OVF      0
`define TCC_FLG_CMP_A    1
`define TCC_FLG_CAP      4
`define TCC_PRE_STOP     2'h0
`define TCC_PRE_DIV1     2'h1
`define TCC_PRE_DIV8     2'h2
`define TCC_PRE_DIV64    2'h3
`define TCC_DIV8_MASK    6'h07
`define TCC_DIV64_MASK   6'h3f
`define TCC_CTRL_RST     8'h00
`define TCC_FLAGS_RST    5'h00
`endif

// File: tcc_pkg.sv
// types of the timer capture/compare block
package tcc_pkg;
   typedef enum logic [3:0] {
      TCC_NORMAL     = 4'h0,
      TCC_PC_TOP_MAX = 4'h1,
      TCC_CTC        = 4'h2,
      TCC_PFC_TOP_A  = 4'h9,
      TCC_PC_TOP_A   = 4'hb
   } tcc_mode_e;
   typedef logic [1:0] tcc_com_t;
endpackage

// File: tcc_timer.sv
// timer/counter with input capture, compare outputs and apb registers
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
`include "tcc_consts.svh"
module tcc_timer #(
   parameter int CNT_W          = 16,
   parameter bit CMP_CAPTURE_EN = 1'b1
) (
   input  wire logic                  clock,
   input  wire logic                  rstn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   input  wire logic                  capture_pin,
   input  wire logic                  comparator_output,
   input  wire logic                  overflow_irq_ack,
   input  wire logic                  compare_a_irq_ack,
   input  wire logic                  capture_irq_ack,
   output logic                       overflow_irq,
   output logic                       compare_a_irq,
   output logic                       capture_irq,
   output logic [2:0]                 waveform_out,
   output logic [2:0]                 waveform_en,
   output tcc_pkg::tcc_mode_e         mode_now
);
   import tcc_pkg::*;

   localparam logic [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
   localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
   localparam logic [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

   logic [7:0]       ctrl_a_reg;
   logic [7:0]       ctrl_b_reg;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic [CNT_W-1:0] cmp_reg [3];
   logic [CNT_W-1:0] capture_reg;
   logic [4:0]       flags_reg;
   logic [4:0]       flags_next;
   logic [4:0]       irq_en_reg;
   logic             up_reg;
   logic             up_next;
   logic             src_prev_reg;
   logic [5:0]       pre_reg;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire       setup_ph = psel & ~penable;
   wire       wr_en    = psel & penable & pready & pwrite;
   wire [7:0] addr     = paddr[`TCC_ADDR_W-1:0];
   wire       hit      = addr == `TCC_OFF_CTRL_A || addr == `TCC_OFF_CTRL_B || addr == `TCC_OFF_COUNT
                         || addr == `TCC_OFF_CMP_A || addr == `TCC_OFF_CMP_B || addr == `TCC_OFF_CMP_C
                         || addr == `TCC_OFF_CAPTURE || addr == `TCC_OFF_FLAGS || addr == `TCC_OFF_IRQ_EN;
   wire       wr_cnt   = wr_en && addr == `TCC_OFF_COUNT;
   wire       wr_flags = wr_en && addr == `TCC_OFF_FLAGS;

   function automatic logic [31:0] pad(input logic [CNT_W-1:0] v);
      pad = 32'(v);
   endfunction

   logic [31:0] rd_mux;
   always_comb begin
      unique case (addr)
         `TCC_OFF_CTRL_A:  rd_mux = {24'h0, ctrl_a_reg};
         `TCC_OFF_CTRL_B:  rd_mux = {24'h0, ctrl_b_reg};
         `TCC_OFF_COUNT:   rd_mux = pad(count_reg);
         `TCC_OFF_CMP_A:   rd_mux = pad(cmp_reg[0]);
         `TCC_OFF_CMP_B:   rd_mux = pad(cmp_reg[1]);
         `TCC_OFF_CMP_C:   rd_mux = pad(cmp_reg[2]);
         `TCC_OFF_CAPTURE: rd_mux = pad(capture_reg);
         `TCC_OFF_FLAGS:   rd_mux = {27'h0, flags_reg};
         `TCC_OFF_IRQ_EN:  rd_mux = {27'h0, irq_en_reg};
         default:          rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup_ph;
         prdata  <= setup_ph ? rd_mux : 32'h0;
         pslverr <= setup_ph & ~hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ctrl_a_reg <= `TCC_CTRL_RST;
         ctrl_b_reg <= `TCC_CTRL_RST;
         irq_en_reg <= `TCC_FLAGS_RST;
      end else if (wr_en) begin
         if (addr == `TCC_OFF_CTRL_A)
            ctrl_a_reg <= pwdata[7:0];
         if (addr == `TCC_OFF_CTRL_B)
            ctrl_b_reg <= pwdata[7:0];
         if (addr == `TCC_OFF_IRQ_EN)
            irq_en_reg <= pwdata[4:0];
      end
   end

   // compare values, written straight through with no double buffer
   for (genvar i = 0; i < 3; i++) begin : g_cmp
      always_ff @(posedge clock) begin
         if (!rstn)
            cmp_reg[i] <= CNT_ZERO;
         else if (wr_en && addr == `TCC_OFF_CMP_A + 8'(4 * i))
            cmp_reg[i] <= pwdata[CNT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timer clock enable
   wire [1:0] pre_sel = ctrl_b_reg[`TCC_PRE_LSB+1:`TCC_PRE_LSB];
   wire       tick    = pre_sel == `TCC_PRE_DIV1
                        || (pre_sel == `TCC_PRE_DIV8 && (pre_reg & `TCC_DIV8_MASK) == 6'h0)
                        || (pre_sel == `TCC_PRE_DIV64 && (pre_reg & `TCC_DIV64_MASK) == 6'h0);

   always_ff @(posedge clock) begin
      if (!rstn || pre_sel == `TCC_PRE_STOP)
         pre_reg <= 6'h0;
      else
         pre_reg <= pre_reg + 6'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // counting sequence
   // mode from both registers
   wire [3:0] mode_bits = {ctrl_b_reg[`TCC_WGM_HI_LSB+1:`TCC_WGM_HI_LSB],
                           ctrl_a_reg[`TCC_WGM_LO_LSB+1:`TCC_WGM_LO_LSB]};
   wire       is_ctc    = mode_bits == TCC_CTC;
   wire       is_dual   = mode_bits == TCC_PC_TOP_MAX || mode_bits == TCC_PFC_TOP_A || mode_bits == TCC_PC_TOP_A;
   wire [CNT_W-1:0] top = mode_bits == TCC_PC_TOP_MAX ? CNT_MAX : cmp_reg[0];
   wire       at_top    = count_reg == top;
   wire       at_max    = count_reg == CNT_MAX;
   wire [2:0] match;

   always_comb begin
      up_next = 1'b1;
      if (is_dual)
         up_next = up_reg ? ~at_top : count_reg == CNT_ZERO;
      if (is_ctc && match[0])
         count_next = CNT_ZERO;
      else if (is_dual && !up_next)
         count_next = count_reg - CNT_ONE;
      else
         count_next = count_reg + CNT_ONE;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         count_reg <= CNT_ZERO;
         up_reg    <= 1'b1;
      end else if (wr_cnt) begin
         count_reg <= pwdata[CNT_W-1:0];
      end else if (tick) begin
         count_reg <= count_next;
         up_reg    <= up_next;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn)
         mode_now <= TCC_NORMAL;
      else
         mode_now <= tcc_mode_e'(mode_bits);
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare outputs
   for (genvar i = 0; i < 3; i++) begin : g_wave
      wire tcc_com_t com = ctrl_a_reg[`TCC_COM_LSB+2*i+1:`TCC_COM_LSB+2*i];
      assign match[i] = tick && count_reg == cmp_reg[i];
      // mode zero disconnects, toggle on all in single-slope modes, only a with top bit in dual-slope
      wire drive = com[1] || (com == 2'h1 && (!is_dual || (i == 0 && mode_bits[3])));
      always_ff @(posedge clock) begin
         if (!rstn) begin
            waveform_out[i] <= 1'b0;
            waveform_en[i]  <= 1'b0;
         end else begin
            waveform_en[i] <= drive;
            if (match[i] && drive) begin
               if (com == 2'h1)
                  waveform_out[i] <= ~waveform_out[i];
               else if (!is_dual)
                  waveform_out[i] <= com[0];
               else
                  waveform_out[i] <= com[0] ~^ up_reg;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input capture
   // comparator source gated by instance
   wire use_cmp  = CMP_CAPTURE_EN && ctrl_b_reg[`TCC_SRC_BIT];
   wire src      = use_cmp ? comparator_output : capture_pin;
   wire cap_trig = (src != src_prev_reg) && (src == ctrl_b_reg[`TCC_EDGE_BIT]);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         src_prev_reg <= 1'b0;
         capture_reg  <= CNT_ZERO;
      end else begin
         src_prev_reg <= src;
         if (cap_trig)
            capture_reg <= count_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags and interrupts
   // overflow point per mode
   wire ovf_set = tick && !wr_cnt && (is_ctc ? at_max : count_next == CNT_ZERO);
   wire [4:0] set_v = {cap_trig, match[2], match[1], match[0], ovf_set};
   wire [4:0] clr_v = (wr_flags ? pwdata[4:0] : 5'h0)
                      | {capture_irq_ack, 2'b00, compare_a_irq_ack, overflow_irq_ack};

   assign flags_next = set_v | (flags_reg & ~clr_v);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         flags_reg     <= `TCC_FLAGS_RST;
         overflow_irq  <= 1'b0;
         compare_a_irq <= 1'b0;
         capture_irq   <= 1'b0;
      end else begin
         flags_reg     <= flags_next;
         overflow_irq  <= flags_next[`TCC_FLG_OVF] & irq_en_reg[`TCC_FLG_OVF];
         compare_a_irq <= flags_next[`TCC_FLG_CMP_A] & irq_en_reg[`TCC_FLG_CMP_A];
         capture_irq   <= flags_next[`TCC_FLG_CAP] & irq_en_reg[`TCC_FLG_CAP];
      end
   end
endmodule

// File: tcc_pins.sv
// pin-side model: capture sources and waveform pin levels
`timescale 1ns/100ps
module tcc_pins (
   input  wire logic       cap_req,
   input  wire logic       cmp_req,
   input  wire logic [2:0] wf_out,
   input  wire logic [2:0] wf_en,
   output logic            capture_pin,
   output logic            comparator_output,
   output logic [2:0]      pin_lvl
);
   assign capture_pin = cap_req;
   assign comparator_output = cmp_req;
   // released pin falls to its pull-up
   assign pin_lvl = (wf_out & wf_en) | ~wf_en;
endmodule

// File: tcc_timer_sva.sv
// checker for timer apb, capture and interrupt ports
`timescale 1ns/100ps
module tcc_timer_chk (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        capture_pin,
   input wire logic        comparator_output,
   input wire logic        overflow_irq_ack,
   input wire logic        compare_a_irq_ack,
   input wire logic        capture_irq_ack,
   input wire logic        overflow_irq,
   input wire logic        compare_a_irq,
   input wire logic        capture_irq,
   input wire logic [2:0]  waveform_en
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   wire wr = psel && penable && pwrite;
   rdy_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready");
   rdy_single_a: assert property (pready |=> !pready) else $error("ready too long");
   err_with_rdy_a: assert property (pslverr |-> pready) else $error("stray error");
   rd_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
   reset_quiet_a: assert property (disable iff (1'b0)
      !rstn |=> !pready && !capture_irq && !overflow_irq && waveform_en == 3'h0) else $error("reset");
   cap_rise_src_a: assert property (
      $rose(capture_irq) |-> $past(capture_pin) != $past(capture_pin, 2)
      || $past(comparator_output) != $past(comparator_output, 2) || $past(wr)) else $error("capture");
   cap_hold_a: assert property (
      capture_irq && !capture_irq_ack && !wr |=> capture_irq) else $error("capture dropped");
   ovf_hold_a: assert property (
      overflow_irq && !overflow_irq_ack && !wr |=> overflow_irq) else $error("overflow dropped");
   cmpa_hold_a: assert property (
      compare_a_irq && !compare_a_irq_ack && !wr |=> compare_a_irq) else $error("compare dropped");
   cap_ack_a: assert property (
      capture_irq_ack && $stable(capture_pin) && $stable(comparator_output) |=> !capture_irq)
      else $error("ack ignored");
   cover property ($rose(capture_irq));
   cover property ($rose(overflow_irq));
   cover property (pready && pslverr);
endmodule
bind tcc_timer tcc_timer_chk chk (.*);

// File: testbench.sv
// self-checking bench for the timer block
`timescale 1ns/100ps
`include "tcc_consts.svh"
module testbench;
   logic        clock, rstn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic        cap_req, cmp_req, capture_pin, comparator_output;
   logic        overflow_irq, compare_a_irq, capture_irq;
   logic [2:0]  ack, waveform_out, waveform_en, pin_lvl;
   logic [3:0]  mode_now;
   int          failures, checks, cyc;
   tcc_timer #(.CNT_W(8), .CMP_CAPTURE_EN(1'b1)) dut (.clock(clock), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .capture_pin(capture_pin),
      .comparator_output(comparator_output), .overflow_irq_ack(ack[0]), .compare_a_irq_ack(ack[1]),
      .capture_irq_ack(ack[2]), .overflow_irq(overflow_irq), .compare_a_irq(compare_a_irq),
      .capture_irq(capture_irq), .waveform_out(waveform_out), .waveform_en(waveform_en),
      .mode_now(mode_now));
   tcc_pins pins (.cap_req(cap_req), .cmp_req(cmp_req), .wf_out(waveform_out), .wf_en(waveform_en),
      .capture_pin(capture_pin), .comparator_output(comparator_output), .pin_lvl(pin_lvl));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         complete_run;
      end
   end
   task automatic complete_run;
      if (failures == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic pulse(input int i);
      ack[i] <= 1'b1;
      @(posedge clock);
      ack[i] <= 1'b0;
      @(posedge clock);
   endtask
   task automatic t_normal;
      apb(0, 8'h40, 32'h0);
      cmp({rd[30:0], err}, 32'h1);
      apb(1, `TCC_OFF_COUNT, 32'hff);
      apb(0, `TCC_OFF_COUNT, 32'h0);
      cmp(rd, 32'hff);
      apb(1, `TCC_OFF_FLAGS, 32'h1f);
      apb(1, `TCC_OFF_IRQ_EN, 32'h01);
      apb(1, `TCC_OFF_CTRL_B, 32'h10);
      apb(0, `TCC_OFF_COUNT, 32'h0);
      cmp(32'(rd < 32'h8), 32'h1);
      cmp(overflow_irq, 1'b1);
      pulse(0);
      cmp(overflow_irq, 1'b0);
   endtask
   task automatic t_ctc;
      apb(1, `TCC_OFF_CTRL_B, 32'h0);
      apb(1, `TCC_OFF_CTRL_A, 32'h2);
      apb(1, `TCC_OFF_CMP_A, 32'h5);
      apb(1, `TCC_OFF_COUNT, 32'h0);
      apb(1, `TCC_OFF_IRQ_EN, 32'h02);
      apb(1, `TCC_OFF_CTRL_B, 32'h10);
      for (int i = 0; i < 6; i++) begin
         apb(0, `TCC_OFF_COUNT, 32'h0);
         cmp(32'(rd <= 32'h5), 32'h1);
      end
      cmp(compare_a_irq, 1'b1);
      apb(1, `TCC_OFF_CTRL_B, 32'h0);
      apb(1, `TCC_OFF_COUNT, 32'h8);
      apb(1, `TCC_OFF_FLAGS, 32'h1f);
      apb(1, `TCC_OFF_CTRL_B, 32'h10);
      repeat (100) @(posedge clock);
      apb(0, `TCC_OFF_FLAGS, 32'h0);
      cmp(rd & 32'h3, 32'h0);
      repeat (200) @(posedge clock);
      apb(0, `TCC_OFF_FLAGS, 32'h0);
      cmp(rd & 32'h3, 32'h3);
   endtask
   task automatic t_capture;
      apb(1, `TCC_OFF_CTRL_B, 32'h04);
      apb(1, `TCC_OFF_COUNT, 32'h5a);
      apb(1, `TCC_OFF_FLAGS, 32'h1f);
      apb(1, `TCC_OFF_IRQ_EN, 32'h10);
      cap_req <= 1'b1;
      repeat (2) @(posedge clock);
      cmp(capture_irq, 1'b1);
      apb(1, `TCC_OFF_COUNT, 32'h33);
      pulse(2);
      cap_req <= 1'b0;
      repeat (3) @(posedge clock);
      cmp(capture_irq, 1'b0);
      apb(0, `TCC_OFF_CAPTURE, 32'h0);
      cmp(rd, 32'h5a);
      apb(1, `TCC_OFF_CTRL_B, 32'h0c);
      cmp_req <= 1'b1;
      repeat (2) @(posedge clock);
      apb(0, `TCC_OFF_CAPTURE, 32'h0);
      cmp(rd, 32'h33);
   endtask
   task automatic t_pwm;
      logic lvl;
      for (int c = 0; c < 4; c++) begin
         apb(1, `TCC_OFF_CTRL_B, 32'h0);
         apb(1, `TCC_OFF_CTRL_A, 32'(c * 4 + 1));
         apb(1, `TCC_OFF_CMP_A, 32'h40);
         apb(1, `TCC_OFF_COUNT, 32'h3e);
         apb(1, `TCC_OFF_CTRL_B, 32'h10);
         repeat (8) @(posedge clock);
         cmp(waveform_en[0], c[1]);
         cmp(pin_lvl[0], c != 2);
         repeat (390) @(posedge clock);
         cmp(pin_lvl[0], c != 3);
         repeat (60) @(posedge clock);
      end
      apb(1, `TCC_OFF_CTRL_B, 32'h02);
      apb(1, `TCC_OFF_CTRL_A, 32'h05);
      repeat (2) @(posedge clock);
      cmp(mode_now, 4'h9);
      cmp(waveform_en[0], 1'b1);
      lvl = pin_lvl[0];
      apb(1, `TCC_OFF_COUNT, 32'h3e);
      apb(1, `TCC_OFF_CTRL_B, 32'h12);
      repeat (8) @(posedge clock);
      cmp(pin_lvl[0], !lvl);
   endtask
   initial begin
      rstn = 1'b0;
      {psel, penable, pwrite, cap_req, cmp_req} = 5'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      ack = 3'h0;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      t_normal;
      t_ctc;
      t_capture;
      t_pwm;
      complete_run;
   end
endmodule
